// *** hw/ecc_map.svh ***
// Constants for the ECC memory and FIFO block
`ifndef ECC_MAP_SVH
`define ECC_MAP_SVH

`define ECC_DATA_W        64
`define ECC_CHECK_W       8
`define ECC_SYN_W         7
`define ECC_WORD_W        72
`define ECC_LAST_POS      71
`define ECC_ADDR_W        9
`define ECC_MEM_DEPTH     512
`define ECC_FIFO_DEPTH    32
`define ECC_GAP_W         9
`define ECC_INJ_BIT_A     30
`define ECC_INJ_BIT_B     62
`define ECC_OVERALL_BIT   7
`define ECC_NEAR_EMPTY_DEF 9'h004
`define ECC_NEAR_FULL_DEF  9'h004

`endif

// *** hw/ecc_pkg.sv ***
// Types shared by the ECC memory and FIFO block
`include "ecc_map.svh"

package ecc_pkg;

	typedef logic [`ECC_DATA_W-1:0]  data_t;
	typedef logic [`ECC_CHECK_W-1:0] check_t;
	typedef logic [`ECC_WORD_W-1:0]  word_t;
	typedef logic [`ECC_ADDR_W-1:0]  addr_t;
	typedef logic [`ECC_GAP_W-1:0]   gap_t;

	// Outcome of decoding one word
	typedef enum logic [2:0] {
		CLASS_CLEAN  = 3'h1,
		CLASS_SINGLE = 3'h2,
		CLASS_DOUBLE = 3'h4
	} err_class_t;

endpackage

// *** hw/ecc_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module ecc_fifo #(
	parameter int WIDTH = 72,
	parameter int DEPTH = 32,
	parameter int PTR_W = $clog2(DEPTH)
) (
	input  wire logic             clk,       // Block clock
	input  wire logic             nrst,      // Async reset, active low
	input  wire logic             in_valid,  // Producer offers a word
	output logic                  in_ready,  // Room for a word
	input  wire logic [WIDTH-1:0] in_data,   // Word to store
	output logic                  out_valid, // A word is waiting
	input  wire logic             out_ready, // Consumer takes the word
	output logic [WIDTH-1:0]      out_data,  // Oldest word
	output logic [PTR_W:0]        count,     // Words held
	output logic [PTR_W-1:0]      wr_ptr,    // Next slot to write
	output logic [PTR_W-1:0]      rd_ptr     // Next slot to read
);

	logic [WIDTH-1:0] store [DEPTH];
	logic             push;
	logic             pop;

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("ecc_fifo: DEPTH must be a power of two, at least 2");
	end

	assign in_ready  = (count != (PTR_W+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = store[rd_ptr];

	// Storage has no reset; only pointers and count do
	always_ff @(posedge clk) begin
		if (push) begin
			store[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// *** hw/memory_ecc_encode_decode.sv ***
// SECDED memory or FIFO with encoder, decoder, error injection and status
`timescale 1ns/1ps
`default_nettype none
`include "ecc_map.svh"

// How it works
// [RQ1] A write while the FIFO is full raises the write overflow flag.
// [RQ2] A read while the FIFO is empty raises the read underflow flag.
// [RQ3] Each read word is clean, single corrected, or double detected, shown on flags.
// [RQ4] Single errors are corrected only at the output, never in storage.
// [RQ5] Standard, encode-only and decode-only modes; both enables default off.
// [RQ6] Output register select: 1 register, 0 latch; memory default 0, FIFO 1.
// [RQ7] Single-clock option forbids preview; without it the output register is required.
// [RQ8] Two 9-bit gaps set near-empty and near-full distances.
// [RQ9] Preview shows the first word of an empty FIFO without a read request.
// [RQ10] Memory takes user addresses; FIFO builds them from its own pointers.
// [RQ11] Encoder makes 8 check bits from 64 data bits; parity input ignored.
// [RQ12] Decoder reads the 72-bit word; clean words come out as stored.
// [RQ13] A single error in data or check bits is corrected; single flag high.
// [RQ14] A double error is passed unchanged with the double flag high.
// [RQ15] Latch mode outputs after the read edge, register mode one edge later.
// [RQ16] Error flags line up with the data and check bits they describe.
// [RQ17] Encode-only mode shows the generated check bits right after each write.
// [RQ18] Encode-only reads are plain reads with both flags low.
// [RQ19] In decode-only mode user logic supplies check bits on the parity input.
// [RQ20] A single error within the check bits is corrected as well.
// [RQ21] Two bad check bits, or one data and one check bit, flag double.
// [RQ22] Encoder on the write side and decoder on the read side work independently.
// [RQ23] Single inject flips stored data bit 30.
// [RQ24] Double inject, alone or with single, flips stored data bits 30 and 62.
// [RQ25] Reset clears counters and flags and is held three clock cycles; here the empty and near-empty flags reset high.
// [RQ26] Error flags go low at each output update lacking that error.
module memory_ecc_encode_decode #(
	parameter bit                  FIFO_MODE      = 1'b1,
	parameter bit                  ENC_EN         = 1'b0,
	parameter bit                  DEC_EN         = 1'b0,
	parameter bit                  OUT_REG        = FIFO_MODE,
	parameter bit                  SINGLE_CLOCK   = 1'b0,
	parameter bit                  PREVIEW        = 1'b0,
	parameter int                  FIFO_DEPTH     = `ECC_FIFO_DEPTH,
	parameter logic [`ECC_GAP_W-1:0] NEAR_EMPTY_GAP = `ECC_NEAR_EMPTY_DEF,
	parameter logic [`ECC_GAP_W-1:0] NEAR_FULL_GAP  = `ECC_NEAR_FULL_DEF
) (
	input  wire logic                  I_REF_CLK,             // Block clock
	input  wire logic                  I_NRST,                // Async reset, active low
	input  wire logic                  I_WRITE_REQUEST,       // Write this cycle
	input  wire logic                  I_READ_REQUEST,        // Read this cycle
	input  wire ecc_pkg::addr_t        I_WRITE_ADDR,          // Memory write address
	input  wire ecc_pkg::addr_t        I_READ_ADDR,           // Memory read address
	input  wire ecc_pkg::data_t        I_DATA,                // Write data
	input  wire ecc_pkg::check_t       I_PARITY_IN,           // Check bits, decode-only
	input  wire logic                  I_INJECT_SINGLE_ERROR, // Flip one bit on write
	input  wire logic                  I_INJECT_DOUBLE_ERROR, // Flip two bits on write
	output ecc_pkg::data_t             O_DATA,                // Read data
	output ecc_pkg::check_t            O_PARITY_OUT,          // Read check bits
	output logic                       O_READ_VALID,          // Output updated
	output logic                       O_SINGLE_ERROR_FLAG,   // Corrected single error
	output logic                       O_DOUBLE_ERROR_FLAG,   // Uncorrected double error
	output ecc_pkg::check_t            O_ENCODED_CHECK_OUT,   // Check bits of last write, encode-only mode
	output logic                       O_FULL,                // FIFO full
	output logic                       O_EMPTY,               // FIFO empty
	output logic                       O_NEAR_FULL_FLAG,      // FIFO near full
	output logic                       O_NEAR_EMPTY_FLAG,     // FIFO near empty
	output logic                       O_WRITE_OVERFLOW_FLAG, // Write refused, full
	output logic                       O_READ_UNDERFLOW_FLAG, // Read refused, empty
	output logic [`ECC_ADDR_W-1:0]     O_WRITE_POINTER,       // FIFO write pointer
	output logic [`ECC_ADDR_W-1:0]     O_READ_POINTER         // FIFO read pointer
);

	localparam int PTR_W = $clog2(FIFO_DEPTH);

	initial begin
		if (SINGLE_CLOCK && PREVIEW)
			$error("Preview is not allowed with the single-clock option"); // [RQ7] [RQ9]
		if (!SINGLE_CLOCK && !OUT_REG)
			$error("Without the single-clock option the output register is required"); // [RQ7]
		if (FIFO_DEPTH > `ECC_MEM_DEPTH || PTR_W + 1 > `ECC_ADDR_W + 1)
			$error("FIFO_DEPTH exceeds the pointer width");
	end

	// Check bits: bits 6:0 are the XOR of the code positions of set data bits,
	// positions skip powers of two; bit 7 is overall parity of the word.
	function automatic ecc_pkg::check_t calc_check(input ecc_pkg::data_t d);
		ecc_pkg::check_t c;
		int              j;
		c = '0;
		j = 0;
		for (int i = 1; i <= `ECC_LAST_POS; i++) begin
			if ((i & (i - 1)) != 0) begin
				if (d[j]) begin
					c[`ECC_SYN_W-1:0] = c[`ECC_SYN_W-1:0] ^ `ECC_SYN_W'(i);
				end
				j++;
			end
		end
		c[`ECC_OVERALL_BIT] = (^d) ^ (^c[`ECC_SYN_W-1:0]);
		return c;
	endfunction

	// Syndrome of a stored word, low 7 bits positional, top bit overall parity
	function automatic ecc_pkg::check_t calc_syndrome(input ecc_pkg::data_t d,
			input ecc_pkg::check_t c);
		ecc_pkg::check_t s;
		s = calc_check(d);
		s[`ECC_SYN_W-1:0] = s[`ECC_SYN_W-1:0] ^ c[`ECC_SYN_W-1:0];
		s[`ECC_OVERALL_BIT] = (^d) ^ (^c);
		return s;
	endfunction

	// Write side
	ecc_pkg::check_t gen_check;
	ecc_pkg::check_t store_check;
	ecc_pkg::data_t  store_data;
	ecc_pkg::word_t  store_word;
	ecc_pkg::word_t  mem [`ECC_MEM_DEPTH];

	assign gen_check   = calc_check(I_DATA);
	assign store_check = ENC_EN ? gen_check : I_PARITY_IN; // [RQ11] [RQ19] [RQ22]

	always_comb begin
		store_data = I_DATA;
		if (I_INJECT_SINGLE_ERROR || I_INJECT_DOUBLE_ERROR) begin
			store_data[`ECC_INJ_BIT_A] = ~I_DATA[`ECC_INJ_BIT_A]; // [RQ23]
		end
		if (I_INJECT_DOUBLE_ERROR) begin
			store_data[`ECC_INJ_BIT_B] = ~I_DATA[`ECC_INJ_BIT_B]; // [RQ24]
		end
	end

	assign store_word = {store_check, store_data};

	// FIFO storage with back-pressure from its own fill level
	logic           fifo_in_ready;
	logic           fifo_out_valid;
	logic           fifo_out_ready;
	ecc_pkg::word_t fifo_out_data;
	logic [PTR_W:0] fifo_count;
	logic [PTR_W-1:0] fifo_wr_ptr;
	logic [PTR_W-1:0] fifo_rd_ptr;
	logic           fifo_push_req;

	assign fifo_push_req = FIFO_MODE && I_WRITE_REQUEST;

	ecc_fifo #(
		.WIDTH (`ECC_WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (I_REF_CLK),
		.nrst      (I_NRST),
		.in_valid  (fifo_push_req),
		.in_ready  (fifo_in_ready),
		.in_data   (store_word),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data),
		.count     (fifo_count),
		.wr_ptr    (fifo_wr_ptr),
		.rd_ptr    (fifo_rd_ptr)
	);

	// Memory storage keeps exactly what was written; correction never writes back
	always_ff @(posedge I_REF_CLK) begin
		if (!FIFO_MODE && I_WRITE_REQUEST) begin
			mem[I_WRITE_ADDR] <= store_word; // [RQ10] [RQ4]
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_ENCODED_CHECK_OUT <= '0;
		end else if (ENC_EN && !DEC_EN && I_WRITE_REQUEST) begin
			O_ENCODED_CHECK_OUT <= gen_check; // [RQ17]
		end
	end

	// Read side: preview keeps a word on show; otherwise reads pop on request
	logic showing;
	logic read_fire;
	logic preview_load;

	assign preview_load   = FIFO_MODE && PREVIEW && !showing && fifo_out_valid; // [RQ9]
	assign fifo_out_ready = FIFO_MODE && (PREVIEW ?
		(!showing || I_READ_REQUEST) : I_READ_REQUEST);
	assign read_fire = FIFO_MODE ? (fifo_out_valid && fifo_out_ready) : I_READ_REQUEST;

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			showing <= 1'b0;
		end else if (FIFO_MODE && PREVIEW) begin
			if (read_fire) begin
				showing <= 1'b1;
			end else if (I_READ_REQUEST) begin
				showing <= 1'b0;
			end
		end
	end

	// Decode
	ecc_pkg::word_t     raw_word;
	ecc_pkg::data_t     raw_data;
	ecc_pkg::check_t    raw_check;
	ecc_pkg::check_t    syn;
	ecc_pkg::data_t     fix_data;
	ecc_pkg::check_t    fix_check;
	ecc_pkg::err_class_t err_class;

	assign raw_word  = FIFO_MODE ? fifo_out_data : mem[I_READ_ADDR]; // [RQ10] [RQ12]
	assign raw_data  = raw_word[`ECC_DATA_W-1:0];
	assign raw_check = raw_word[`ECC_WORD_W-1:`ECC_DATA_W];
	assign syn       = calc_syndrome(raw_data, raw_check);

	always_comb begin
		int j;
		j         = 0;
		fix_data  = raw_data;
		fix_check = raw_check;
		err_class = ecc_pkg::CLASS_CLEAN;
		if (!DEC_EN) begin
			err_class = ecc_pkg::CLASS_CLEAN; // [RQ18]
		end else if (syn[`ECC_OVERALL_BIT]) begin
			err_class = ecc_pkg::CLASS_SINGLE; // [RQ13]
			if (syn[`ECC_SYN_W-1:0] == '0) begin
				fix_check[`ECC_OVERALL_BIT] = ~raw_check[`ECC_OVERALL_BIT]; // [RQ20]
			end else if ((syn[`ECC_SYN_W-1:0] & (syn[`ECC_SYN_W-1:0] - 1'b1)) == '0) begin
				for (int k = 0; k < `ECC_SYN_W; k++) begin
					if (syn[k]) begin
						fix_check[k] = ~raw_check[k]; // [RQ20]
					end
				end
			end else if (syn[`ECC_SYN_W-1:0] > `ECC_SYN_W'(`ECC_LAST_POS)) begin
				// Odd parity but no real position: more than one bit is bad
				err_class = ecc_pkg::CLASS_DOUBLE;
			end else begin
				for (int i = 1; i <= `ECC_LAST_POS; i++) begin
					if ((i & (i - 1)) != 0) begin
						if (`ECC_SYN_W'(i) == syn[`ECC_SYN_W-1:0]) begin
							fix_data[j] = ~raw_data[j]; // [RQ13] [RQ4]
						end
						j++;
					end
				end
			end
		end else if (syn[`ECC_SYN_W-1:0] != '0) begin
			err_class = ecc_pkg::CLASS_DOUBLE; // [RQ14] [RQ21]
		end
		if (err_class == ecc_pkg::CLASS_DOUBLE) begin
			fix_data  = raw_data; // [RQ14]
			fix_check = raw_check;
		end
	end

	// Pipeline stage used only in register mode
	ecc_pkg::data_t  pipe_data;
	ecc_pkg::check_t pipe_check;
	logic            pipe_single;
	logic            pipe_double;
	logic            pipe_valid;

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			pipe_data   <= '0;
			pipe_check  <= '0;
			pipe_single <= 1'b0;
			pipe_double <= 1'b0;
			pipe_valid  <= 1'b0;
		end else begin
			pipe_valid <= read_fire && !preview_load;
			if (read_fire) begin
				pipe_data   <= fix_data;
				pipe_check  <= fix_check;
				pipe_single <= (err_class == ecc_pkg::CLASS_SINGLE);
				pipe_double <= (err_class == ecc_pkg::CLASS_DOUBLE);
			end
		end
	end

	// Output stage: one flop set whose source depends on the mode, so the
	// flags travel with their word in both latch and register mode.
	logic out_load;
	logic out_pulse;

	assign out_load  = OUT_REG ? (pipe_valid || (PREVIEW && read_fire)) : read_fire; // [RQ6]
	assign out_pulse = OUT_REG ? pipe_valid : (read_fire && !preview_load); // [RQ15]

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_DATA              <= '0;
			O_PARITY_OUT        <= '0;
			O_SINGLE_ERROR_FLAG <= 1'b0;
			O_DOUBLE_ERROR_FLAG <= 1'b0;
		end else if (out_load) begin
			if (OUT_REG && !(PREVIEW && read_fire && !pipe_valid)) begin
				O_DATA              <= pipe_data; // [RQ15]
				O_PARITY_OUT        <= pipe_check;
				O_SINGLE_ERROR_FLAG <= pipe_single; // [RQ16] [RQ26]
				O_DOUBLE_ERROR_FLAG <= pipe_double; // [RQ16] [RQ26]
			end else begin
				O_DATA              <= fix_data; // [RQ15]
				O_PARITY_OUT        <= fix_check;
				O_SINGLE_ERROR_FLAG <= (err_class == ecc_pkg::CLASS_SINGLE); // [RQ3] [RQ26]
				O_DOUBLE_ERROR_FLAG <= (err_class == ecc_pkg::CLASS_DOUBLE); // [RQ3] [RQ26]
			end
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_READ_VALID <= 1'b0;
		end else begin
			O_READ_VALID <= out_pulse;
		end
	end

	// FIFO status; counters and flags clear on reset, except empty and near-empty, which set
	logic [`ECC_ADDR_W:0] count_wide;
	logic                 next_near_empty;
	logic                 next_near_full;

	assign count_wide      = (`ECC_ADDR_W+1)'(fifo_count);
	assign next_near_empty = (count_wide <= {1'b0, NEAR_EMPTY_GAP}); // [RQ8]
	assign next_near_full  = (count_wide + {1'b0, NEAR_FULL_GAP}
		>= (`ECC_ADDR_W+1)'(FIFO_DEPTH)); // [RQ8]

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_FULL            <= 1'b0;
			O_EMPTY           <= 1'b1;
			O_NEAR_FULL_FLAG  <= 1'b0;
			O_NEAR_EMPTY_FLAG <= 1'b1;
			O_WRITE_POINTER   <= '0;
			O_READ_POINTER    <= '0;
		end else begin
			O_FULL            <= FIFO_MODE && !fifo_in_ready;
			O_EMPTY           <= !FIFO_MODE || !fifo_out_valid;
			O_NEAR_FULL_FLAG  <= FIFO_MODE && next_near_full;
			O_NEAR_EMPTY_FLAG <= !FIFO_MODE || next_near_empty;
			O_WRITE_POINTER   <= `ECC_ADDR_W'(fifo_wr_ptr); // [RQ10]
			O_READ_POINTER    <= `ECC_ADDR_W'(fifo_rd_ptr); // [RQ10]
		end
	end

	// Refused accesses, one flag pulse per refused attempt
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_WRITE_OVERFLOW_FLAG <= 1'b0;
			O_READ_UNDERFLOW_FLAG <= 1'b0;
		end else begin
			O_WRITE_OVERFLOW_FLAG <= FIFO_MODE && I_WRITE_REQUEST && !fifo_in_ready; // [RQ1]
			O_READ_UNDERFLOW_FLAG <= FIFO_MODE && I_READ_REQUEST &&
				(PREVIEW ? !showing : !fifo_out_valid); // [RQ2]
		end
	end

endmodule

`default_nettype wire

// *** tb/ecc_fifo_monitor.sv ***
// Concurrent checks on the ECC FIFO top ports
`timescale 1ns/1ps
`default_nettype none

module ecc_fifo_monitor (
	input wire logic            I_REF_CLK,             // Block clock
	input wire logic            I_NRST,                // Reset, active low
	input wire logic            I_WRITE_REQUEST,       // Write request
	input wire logic            I_READ_REQUEST,        // Read request
	input wire ecc_pkg::data_t  O_DATA,                // Read data
	input wire ecc_pkg::check_t O_PARITY_OUT,          // Read check bits
	input wire logic            O_READ_VALID,          // Output updated
	input wire logic            O_SINGLE_ERROR_FLAG,   // Single error
	input wire logic            O_DOUBLE_ERROR_FLAG,   // Double error
	input wire logic            O_FULL,                // Full
	input wire logic            O_EMPTY,               // Empty
	input wire logic            O_NEAR_FULL_FLAG,      // Near full
	input wire logic            O_NEAR_EMPTY_FLAG,     // Near empty
	input wire logic            O_WRITE_OVERFLOW_FLAG, // Write refused
	input wire logic            O_READ_UNDERFLOW_FLAG, // Read refused
	input wire logic [8:0]      O_WRITE_POINTER        // Write pointer
);
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_NRST);

	// Register mode: two edges from request to output
	property p_rd_latency;
		O_READ_VALID |-> $past(I_READ_REQUEST, 2);
	endproperty
	a_rd_latency: assert property (p_rd_latency) else $error("output without read");
	property p_flag_excl;
		!(O_SINGLE_ERROR_FLAG && O_DOUBLE_ERROR_FLAG);
	endproperty
	a_flag_excl: assert property (p_flag_excl) else $error("both error flags");
	property p_flag_hold;
		!O_READ_VALID |-> $stable({O_SINGLE_ERROR_FLAG, O_DOUBLE_ERROR_FLAG});
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag moved alone");
	property p_data_hold;
		!O_READ_VALID |-> $stable(O_DATA) && $stable(O_PARITY_OUT);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data moved alone");
	property p_overflow;
		O_WRITE_OVERFLOW_FLAG |-> $past(I_WRITE_REQUEST) && O_FULL;
	endproperty
	a_overflow: assert property (p_overflow) else $error("stray overflow");
	// The refused read must never produce an output update
	property p_underflow;
		O_READ_UNDERFLOW_FLAG |-> $past(I_READ_REQUEST) && O_EMPTY ##1 !O_READ_VALID;
	endproperty
	a_underflow: assert property (p_underflow) else $error("bad underflow");
	property p_full_flags;
		O_FULL |-> O_NEAR_FULL_FLAG && !O_EMPTY;
	endproperty
	a_full_flags: assert property (p_full_flags) else $error("full flag set wrong");
	property p_empty_flags;
		O_EMPTY |-> O_NEAR_EMPTY_FLAG && !O_NEAR_FULL_FLAG;
	endproperty
	a_empty_flags: assert property (p_empty_flags) else $error("empty flag set wrong");
	property p_full_rise;
		$rose(O_FULL) |-> $past(I_WRITE_REQUEST, 2);
	endproperty
	a_full_rise: assert property (p_full_rise) else $error("full without write");
	property p_wptr_step;
		$changed(O_WRITE_POINTER) |-> $past(I_WRITE_REQUEST, 2);
	endproperty
	a_wptr_step: assert property (p_wptr_step) else $error("pointer moved alone");

	cover property (O_READ_VALID && O_SINGLE_ERROR_FLAG);
	cover property (O_READ_VALID && O_DOUBLE_ERROR_FLAG);
	cover property (O_WRITE_OVERFLOW_FLAG);
endmodule

`default_nettype wire

// *** tb/user_port_model.sv ***
// User logic on the write and read ports of the ECC FIFO
`timescale 1ns/1ps
`default_nettype none

module user_port_model (
	input  wire logic            clk,    // Block clock
	input  wire logic            rd_vld, // Output updated
	input  wire ecc_pkg::data_t  rdata,  // Read data
	input  wire ecc_pkg::check_t rpar,   // Read check bits
	input  wire logic            s_flag, // Single error
	input  wire logic            d_flag, // Double error
	output logic                 wr_req, // Write request
	output logic                 rd_req, // Read request
	output ecc_pkg::data_t       wdata,  // Write data
	output ecc_pkg::check_t      par,    // Parity input
	output logic                 inj_s,  // Inject single
	output logic                 inj_d   // Inject double
);
	logic [73:0] got[$];

	initial begin
		wr_req = 1'b0;
		rd_req = 1'b0;
		wdata = 64'h0;
		par = 8'h00;
		inj_s = 1'b0;
		inj_d = 1'b0;
	end

	// One cycle of requests; idle data lines flip so stale data never looks valid
	task automatic drive(input logic w, input logic r, input ecc_pkg::data_t d,
		input logic [1:0] inj, input ecc_pkg::check_t p = 8'h00);
		@(negedge clk);
		wr_req <= w;
		rd_req <= r;
		wdata <= w ? d : ~wdata;
		par <= p;
		inj_s <= w & inj[0];
		inj_d <= w & inj[1];
	endtask

	always @(negedge clk) begin
		if (rd_vld === 1'b1) begin
			got.push_back({s_flag, d_flag, rpar, rdata});
		end
	end
endmodule

`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the ECC FIFO in standard and decode-only modes
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic            clk, nrst, wr_req, rd_req, inj_s, inj_d;
	logic            rd_vld, s_flag, d_flag, full, empty, near_full, near_empty, ovf, unf;
	ecc_pkg::data_t  wdata, rdata;
	ecc_pkg::check_t par, rpar;
	logic [8:0]      wptr, rptr;
	int              n_fail, total_checks;
	logic            rd_vld2, s_flag2, d_flag2;
	ecc_pkg::data_t  rdata2;
	ecc_pkg::check_t rpar2, enc;
	logic [73:0]     got2[$];

	// Addresses are ignored in FIFO mode; fed from the pointers rather than tied
	memory_ecc_encode_decode #(.ENC_EN(1'b1), .DEC_EN(1'b1)) dut_u (
		.I_REF_CLK(clk), .I_NRST(nrst), .I_WRITE_REQUEST(wr_req), .I_READ_REQUEST(rd_req),
		.I_WRITE_ADDR(wptr), .I_READ_ADDR(rptr), .I_DATA(wdata), .I_PARITY_IN(par),
		.I_INJECT_SINGLE_ERROR(inj_s), .I_INJECT_DOUBLE_ERROR(inj_d), .O_DATA(rdata),
		.O_PARITY_OUT(rpar), .O_READ_VALID(rd_vld), .O_SINGLE_ERROR_FLAG(s_flag),
		.O_DOUBLE_ERROR_FLAG(d_flag), .O_ENCODED_CHECK_OUT(enc), .O_FULL(full), .O_EMPTY(empty),
		.O_NEAR_FULL_FLAG(near_full), .O_NEAR_EMPTY_FLAG(near_empty),
		.O_WRITE_OVERFLOW_FLAG(ovf), .O_READ_UNDERFLOW_FLAG(unf),
		.O_WRITE_POINTER(wptr), .O_READ_POINTER(rptr));

	// Decode-only twin on the same stimulus; check bits come from the parity input
	memory_ecc_encode_decode #(.ENC_EN(1'b0), .DEC_EN(1'b1)) dec_u (
		.I_REF_CLK(clk), .I_NRST(nrst), .I_WRITE_REQUEST(wr_req), .I_READ_REQUEST(rd_req),
		.I_WRITE_ADDR(wptr), .I_READ_ADDR(rptr), .I_DATA(wdata), .I_PARITY_IN(par),
		.I_INJECT_SINGLE_ERROR(inj_s), .I_INJECT_DOUBLE_ERROR(inj_d), .O_DATA(rdata2),
		.O_PARITY_OUT(rpar2), .O_READ_VALID(rd_vld2), .O_SINGLE_ERROR_FLAG(s_flag2),
		.O_DOUBLE_ERROR_FLAG(d_flag2), .O_ENCODED_CHECK_OUT(), .O_FULL(), .O_EMPTY(),
		.O_NEAR_FULL_FLAG(), .O_NEAR_EMPTY_FLAG(), .O_WRITE_OVERFLOW_FLAG(),
		.O_READ_UNDERFLOW_FLAG(), .O_WRITE_POINTER(), .O_READ_POINTER());

	always @(negedge clk) begin
		if (rd_vld2 === 1'b1)
			got2.push_back({s_flag2, d_flag2, rpar2, rdata2});
	end

	user_port_model pm_u (.clk(clk), .rd_vld(rd_vld), .rdata(rdata), .rpar(rpar),
		.s_flag(s_flag), .d_flag(d_flag), .wr_req(wr_req), .rd_req(rd_req), .wdata(wdata),
		.par(par), .inj_s(inj_s), .inj_d(inj_d));

	function automatic ecc_pkg::check_t calc_check(input ecc_pkg::data_t d);
		logic [6:0] s;
		int j;
		s = 7'h00;
		j = 0;
		for (int p = 1; p <= 71; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (d[j])
					s ^= p[6:0];
				j++;
			end
		end
		return {^{d, s}, s};
	endfunction

	// Double injection leaves data flipped; single is corrected away
	function automatic logic [73:0] exp_word(input ecc_pkg::data_t d, input logic [1:0] inj);
		if (inj[1])
			return {2'b01, calc_check(d), d ^ 64'h4000000040000000};
		return {inj[0], 1'b0, calc_check(d), d};
	endfunction

	// Decode-only: corrected words come back clean, the rest exactly as stored
	function automatic logic [73:0] exp_dec(input ecc_pkg::data_t d, input logic [1:0] inj,
		input ecc_pkg::check_t pe, input logic [1:0] sd);
		if (sd[1])
			return {sd, calc_check(d), d};
		return {sd, calc_check(d) ^ pe, d ^ {1'b0, inj[1], 31'h0, |inj, 30'h0}};
	endfunction

	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (!ok) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic expect_word(input logic [73:0] e);
		logic [73:0] g;
		if (pm_u.got.size() == 0) begin
			chk(1'b0, "read word missing");
		end else begin
			g = pm_u.got.pop_front();
			chk(g === e, "read word mismatch");
		end
	endtask

	task automatic idle(input int n);
		repeat (n) pm_u.drive(1'b0, 1'b0, 64'h0, 2'b00);
	endtask

	task automatic t_reset();
		chk(empty === 1'b1 && near_empty === 1'b1 && full === 1'b0, "reset flags");
		chk(rd_vld === 1'b0 && s_flag === 1'b0 && d_flag === 1'b0, "reset outputs");
	endtask

	task automatic t_ecc();
		ecc_pkg::data_t dv[5];
		logic [1:0] iv[5];
		logic [1:0] sd[5];
		ecc_pkg::check_t pe[5];
		dv = '{64'h0123456789abcdef, 64'hfedcba9876543210, 64'h00000000ffffffff,
			64'h8000000000000001, 64'h5555aaaa5555aaaa};
		iv = '{2'b00, 2'b01, 2'b10, 2'b00, 2'b11};
		// Check-bit damage: two check bits, data plus check, none, one check bit, none
		pe = '{8'h03, 8'h04, 8'h00, 8'h10, 8'h00};
		sd = '{2'b01, 2'b01, 2'b01, 2'b10, 2'b01};
		for (int i = 0; i < 5; i++)
			pm_u.drive(1'b1, 1'b0, dv[i], iv[i], calc_check(dv[i]) ^ pe[i]);
		idle(1);
		repeat (5) pm_u.drive(1'b0, 1'b1, 64'h0, 2'b00);
		idle(4);
		for (int i = 0; i < 5; i++) begin
			expect_word(exp_word(dv[i], iv[i]));
			chk(got2.size() > 0 &&
				got2.pop_front() === exp_dec(dv[i], iv[i], pe[i], sd[i]), "dec word");
		end
		chk(enc === 8'h00, "check output moved outside encode-only");
	endtask

	task automatic t_underflow();
		pm_u.drive(1'b0, 1'b1, 64'h0, 2'b00);
		idle(1);
		chk(unf === 1'b1, "no underflow pulse");
		idle(3);
		chk(unf === 1'b0 && pm_u.got.size() == 0, "underflow gave data");
	endtask

	// Five words already passed through, so both pointers end at five
	task automatic t_fill();
		for (int i = 0; i < 33; i++) begin
			if (i == 29)
				chk(near_full === 1'b0, "near full early");
			if (i == 30)
				chk(near_full === 1'b1 && near_empty === 1'b0, "near full late");
			pm_u.drive(1'b1, 1'b0, 64'(i) << 8, 2'b00);
		end
		idle(1);
		chk(ovf === 1'b1 && full === 1'b1, "overflow not flagged");
		idle(1);
		chk(ovf === 1'b0 && wptr === 9'h005, "overflow pulse or pointer");
		for (int i = 0; i < 32; i++) begin
			pm_u.drive(1'b0, 1'b1, 64'h0, 2'b00);
			idle(1);
		end
		idle(3);
		chk(empty === 1'b1 && rptr === 9'h005, "drain end");
		for (int i = 0; i < 32; i++)
			expect_word(exp_word(64'(i) << 8, 2'b00));
		chk(pm_u.got.size() == 0, "refused word stored");
	endtask

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial begin
		n_fail = 0;
		total_checks = 0;
		nrst = 1'b0;
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		t_reset();
		t_ecc();
		t_underflow();
		t_fill();
		complete_run();
	end

	// Whole sequence needs about 140 cycles
	initial begin
		repeat (3000) @(posedge clk);
		n_fail++;
		complete_run();
	end
endmodule

bind memory_ecc_encode_decode ecc_fifo_monitor mon_u (.I_REF_CLK, .I_NRST, .I_WRITE_REQUEST,
	.I_READ_REQUEST, .O_DATA, .O_PARITY_OUT, .O_READ_VALID, .O_SINGLE_ERROR_FLAG,
	.O_DOUBLE_ERROR_FLAG, .O_FULL, .O_EMPTY, .O_NEAR_FULL_FLAG, .O_NEAR_EMPTY_FLAG,
	.O_WRITE_OVERFLOW_FLAG, .O_READ_UNDERFLOW_FLAG, .O_WRITE_POINTER);

`default_nettype wire
